// >>> fcs_fifo.v
`timescale 1ns/1ps
`default_nettype none
module fcs_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             ref_clk_in,
  input  wire             sys_rst_in,
  input  wire [WIDTH-1:0] wr_data_in,
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  output wire [WIDTH-1:0] rd_data_out,
  output wire             rd_valid_out,
  input  wire             rd_ready_in
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wp_reg;
  reg [AW-1:0]    rp_reg;
  reg [AW:0]      cnt_reg;
  wire wr_go = wr_valid_in && (cnt_reg != DEPTH);
  wire rd_go = rd_ready_in && (cnt_reg != 0);
  assign wr_ready_out = (cnt_reg != DEPTH);
  assign rd_valid_out = (cnt_reg != 0);
  assign rd_data_out  = mem_reg[rp_reg];
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      wp_reg  <= {AW{1'b0}};
      rp_reg  <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (wr_go) begin
        mem_reg[wp_reg] <= wr_data_in;
        wp_reg          <= (wp_reg == DEPTH-1) ? {AW{1'b0}} : wp_reg + 1'b1;
      end
      if (rd_go)
        rp_reg <= (rp_reg == DEPTH-1) ? {AW{1'b0}} : rp_reg + 1'b1;
      if (wr_go && !rd_go)
        cnt_reg <= cnt_reg + 1'b1;
      else if (rd_go && !wr_go)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> fcs_map.vh
`ifndef FCS_MAP_VH
`define FCS_MAP_VH
// mode pin codes {mode_sel2, mode_sel1, mode_sel0}
`define FCS_MODE_MSER      3'h0
`define FCS_MODE_SSER      3'h7
`define FCS_MODE_MPAR_UP   3'h4
`define FCS_MODE_MPAR_DN   3'h6
`define FCS_MODE_SYNC_PER  3'h3
`define FCS_MODE_ASYNC_PER 3'h5
`define FCS_MODE_RSV0      3'h2
`define FCS_MODE_RSV1      3'h1
// header format and start-up extra clocks
`define FCS_PREAMBLE       4'h2
`define FCS_LEN_BITS       24
`define FCS_EXTRA_CLKS     3'h4
// clock figures
`define FCS_SYS_MHZ        125
`define FCS_SLOW_MHZ       1
`define FCS_FAST_FACTOR    8
// init settle times in us, mode sample delay in cycles
`define FCS_INIT_MIN_US    50
`define FCS_INIT_MAX_US    250
`define FCS_SLAVE_WAIT_US  250
`define FCS_MODE_DLY       2
`endif

// >>> fcs_prom.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_prom (
  input  wire logic         clk_in,
  input  wire logic         ce_n_in,
  input  wire logic         rst_n_in,
  input  wire logic [0:127] strm_in,
  output var  logic         data_out
);
  int addr;
  initial data_out = 1'h1;
  // ==========
  // serial output
  // released output inverts so a stale bit never looks valid
  always @(negedge rst_n_in or posedge ce_n_in) data_out <= ~data_out;
  always @(posedge rst_n_in) begin
    addr = 1;
    data_out <= strm_in[0];
  end
  always @(posedge clk_in) begin
    if (!ce_n_in && rst_n_in) begin
      data_out <= strm_in[addr[6:0]];
      addr = addr + 1;
    end
  end
endmodule
`default_nettype wire

// >>> fcs_sequencer.v
`timescale 1ns/1ps
`default_nettype none
`include "fcs_map.vh"
module fcs_sequencer #(
  parameter FRAMES        = 16,
  parameter FRAME_BITS    = 8,
  parameter POR_CYCLES    = 5000,
  parameter INIT_MIN_CYC  = `FCS_INIT_MIN_US * `FCS_SYS_MHZ,
  parameter SLAVE_WAIT_CY = `FCS_SLAVE_WAIT_US * `FCS_SYS_MHZ,
  parameter RATE_BIT_POS  = 4
) (
  input  wire        ref_clk_in,
  input  wire        sys_rst_in,
  input  wire        program_n_in,
  input  wire        init_n_in,
  output reg         init_n_oe_out,
  output reg         init_n_out,
  input  wire        mode_sel0_in,
  input  wire        mode_sel1_in,
  input  wire        mode_sel2_in,
  input  wire        din_in,
  input  wire        config_clk_in,
  output reg         config_clk_out,
  output reg         config_clk_oe_out,
  input  wire        read_clk_in,
  output reg         dout_out,
  output reg         done_out,
  output reg         low_during_cfg_n_out,
  output reg         high_during_cfg_out,
  output reg         gsr_out,
  output reg         user_io_en_out,
  output reg         cfg_error_out,
  output reg  [2:0]  mode_out,
  output reg         fast_rate_out,
  input  wire [1:0]  done_step_in,
  input  wire [1:0]  gsr_step_in,
  input  wire [1:0]  io_step_in,
  input  wire        fast_rate_option_in
);
  // ==========================================================
  // timing constants, state and phase codes
  localparam SLOW_DIV  = `FCS_SYS_MHZ / `FCS_SLOW_MHZ;
  localparam FAST_DIV  = SLOW_DIV / `FCS_FAST_FACTOR;
  localparam [3:0] ST_CLEAR = 4'h1;
  localparam [3:0] ST_WAIT  = 4'h2;
  localparam [3:0] ST_LOAD  = 4'h4;
  localparam [3:0] ST_START = 4'h8;
  localparam [5:0] PH_HDR   = 6'h01;
  localparam [5:0] PH_LEN   = 6'h02;
  localparam [5:0] PH_FRM   = 6'h04;
  localparam [5:0] PH_PASS  = 6'h08;
  localparam [5:0] PH_ERR   = 6'h10;
  localparam [5:0] PH_IDLE  = 6'h20;

  // ==========================================================
  // pin synchronisers
  reg [1:0] prog_s_reg, init_s_reg, din_s_reg, config_clk_s_reg, rclk_s_reg;
  reg [2:0] m_s1_reg, m_s2_reg;
  reg       config_clk_d_reg, rclk_d_reg;
  always @(posedge ref_clk_in) begin
    prog_s_reg <= {prog_s_reg[0], program_n_in};
    init_s_reg <= {init_s_reg[0], init_n_in};
    din_s_reg  <= {din_s_reg[0], din_in};
    config_clk_s_reg <= {config_clk_s_reg[0], config_clk_in};
    rclk_s_reg <= {rclk_s_reg[0], read_clk_in};
    m_s1_reg   <= {mode_sel2_in, mode_sel1_in, mode_sel0_in};
    m_s2_reg   <= m_s1_reg;
    config_clk_d_reg <= config_clk_s_reg[1];
    rclk_d_reg <= rclk_s_reg[1];
  end
  wire prog_low = ~prog_s_reg[1];
  wire init_hi  = init_s_reg[1];
  wire ext_rise = config_clk_s_reg[1] & ~config_clk_d_reg;
  wire rclk_end = rclk_s_reg[1] & ~rclk_d_reg;

  // ==========================================================
  // state registers
  reg [3:0]  state_reg;
  reg [31:0] por_cnt_reg, wait_cnt_reg;
  reg [15:0] frm_addr_reg;
  reg        last_pass_reg;
  reg [1:0]  mode_dly_reg;
  reg        master_reg;
  reg        par_wait_reg;
  reg [7:0]  div_cnt_reg;
  reg        clk_run_reg;
  reg [5:0]  ph_reg;
  reg [3:0]  pre_reg;
  reg [23:0] len_reg, len_cnt_reg;
  reg [4:0]  len_bits_reg;
  reg [15:0] frm_cnt_reg, bit_cnt_reg;
  reg        parity_reg;
  reg [2:0]  extra_reg;
  reg [2:0]  su_cnt_reg;
  reg        fwd_reg;
  wire por_busy = (por_cnt_reg != POR_CYCLES);
  wire [2:0] mode_pins = m_s2_reg;
  wire mode_master = (mode_pins == `FCS_MODE_MSER) || (mode_pins == `FCS_MODE_MPAR_UP) ||
                     (mode_pins == `FCS_MODE_MPAR_DN) || (mode_pins == `FCS_MODE_ASYNC_PER);
  wire mode_rsv = (mode_pins == `FCS_MODE_RSV0) || (mode_pins == `FCS_MODE_RSV1);

  // ==========================================================
  // config clock: own divider in master modes, sampled pin otherwise
  wire [7:0] div_top = fast_rate_out ? FAST_DIV[7:0] : SLOW_DIV[7:0];
  wire master_rise = master_reg && clk_run_reg && (div_cnt_reg == 8'h00);
  wire master_fall = master_reg && clk_run_reg && (div_cnt_reg == {1'b0, div_top[7:1]});
  wire rise = (state_reg == ST_LOAD || state_reg == ST_START) &&
              (master_reg ? master_rise : ext_rise);
  wire slave_fall = ~master_reg && ~config_clk_s_reg[1] && config_clk_d_reg;
  wire fall = master_reg ? master_fall : slave_fall;

  // forwarding buffer between sampling on rise and driving on fall
  wire fifo_in_ready, fifo_out_valid, fifo_out_data;
  fcs_fifo #(.WIDTH(1), .DEPTH(8), .AW(3)) u_fwd (
    .ref_clk_in   (ref_clk_in),
    .sys_rst_in   (sys_rst_in | (state_reg == ST_CLEAR)),
    .wr_data_in   (fwd_reg ? din_s_reg[1] : 1'b1),
    .wr_valid_in  (rise && (ph_reg != PH_IDLE)),
    .wr_ready_out (fifo_in_ready),
    .rd_data_out  (fifo_out_data),
    .rd_valid_out (fifo_out_valid),
    .rd_ready_in  (fall)
  );

  // ==========================================================
  // main sequencer
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state_reg <= ST_CLEAR;
      por_cnt_reg <= 32'h0; wait_cnt_reg <= 32'h0;
      frm_addr_reg <= 16'h0; last_pass_reg <= 1'b0; mode_dly_reg <= 2'h0;
      master_reg <= 1'b0; par_wait_reg <= 1'b0; div_cnt_reg <= 8'h00;
      clk_run_reg <= 1'b0; ph_reg <= PH_HDR; pre_reg <= 4'hF;
      len_reg <= 24'h0; len_cnt_reg <= 24'h0; len_bits_reg <= 5'h0;
      frm_cnt_reg <= 16'h0; bit_cnt_reg <= 16'h0; parity_reg <= 1'b0;
      extra_reg <= 3'h0; su_cnt_reg <= 3'h0; fwd_reg <= 1'b1;
      init_n_oe_out <= 1'b1; init_n_out <= 1'b0;
      config_clk_out <= 1'b0; config_clk_oe_out <= 1'b0;
      dout_out <= 1'b1; done_out <= 1'b0;
      low_during_cfg_n_out <= 1'b0; high_during_cfg_out <= 1'b1;
      gsr_out <= 1'b1; user_io_en_out <= 1'b0;
      cfg_error_out <= 1'b0; mode_out <= 3'h0; fast_rate_out <= 1'b0;
    end else begin
      if (por_busy)
        por_cnt_reg <= por_cnt_reg + 32'h1;
      if (prog_low) begin
        // a low program pin restarts configuration from ST_CLEAR
        state_reg <= ST_CLEAR;
        init_n_oe_out <= 1'b1;
        init_n_out <= 1'b0;
        last_pass_reg <= 1'b0;
        done_out <= 1'b0; gsr_out <= 1'b1; user_io_en_out <= 1'b0;
        low_during_cfg_n_out <= 1'b0; high_during_cfg_out <= 1'b1;
        config_clk_oe_out <= 1'b0; fast_rate_out <= 1'b0;
        config_clk_out <= 1'b0;
      end
      // program low must win over any load or start-up transition
      case (prog_low ? ST_CLEAR : state_reg)
        ST_CLEAR: begin
          cfg_error_out <= 1'b0;
          frm_addr_reg <= (frm_addr_reg == FRAMES-1) ? 16'h0 : frm_addr_reg + 16'h1;
          if (frm_addr_reg == FRAMES-1) begin
            if (por_busy || prog_low)
              last_pass_reg <= 1'b0;
            else if (!last_pass_reg)
              last_pass_reg <= 1'b1;
            else begin
              state_reg <= ST_WAIT;
              init_n_oe_out <= 1'b0;
              wait_cnt_reg <= 32'h0;
              mode_dly_reg <= 2'h0;
            end
          end
        end
        ST_WAIT: begin
          // external low on init holds us here
          if (!init_hi) begin
            wait_cnt_reg <= 32'h0;
            mode_dly_reg <= 2'h0;
          end else if (wait_cnt_reg < INIT_MIN_CYC + SLAVE_WAIT_CY) begin
            wait_cnt_reg <= wait_cnt_reg + 32'h1;
            if (wait_cnt_reg >= INIT_MIN_CYC && !mode_master && mode_dly_reg == 2'h2)
              wait_cnt_reg <= INIT_MIN_CYC + SLAVE_WAIT_CY;
            if (mode_dly_reg != `FCS_MODE_DLY)
              mode_dly_reg <= mode_dly_reg + 2'h1;
          end else if (!mode_rsv) begin
            mode_out <= mode_pins;
            master_reg <= mode_master;
            config_clk_oe_out <= mode_master;
            par_wait_reg <= (mode_pins == `FCS_MODE_MPAR_UP) ||
                            (mode_pins == `FCS_MODE_MPAR_DN);
            clk_run_reg <= !((mode_pins == `FCS_MODE_MPAR_UP) ||
                             (mode_pins == `FCS_MODE_MPAR_DN));
            state_reg <= ST_LOAD;
            ph_reg <= PH_HDR; pre_reg <= 4'hF; fwd_reg <= 1'b1;
            len_cnt_reg <= 24'h0;
            len_bits_reg <= 5'h0; frm_cnt_reg <= 16'h0; bit_cnt_reg <= 16'h0;
            div_cnt_reg <= 8'h00; extra_reg <= 3'h0; su_cnt_reg <= 3'h0;
          end
        end
        ST_LOAD, ST_START: begin
          if (par_wait_reg && rclk_end) begin
            par_wait_reg <= 1'b0;
            clk_run_reg <= 1'b1;
          end
          if (master_reg && clk_run_reg) begin
            div_cnt_reg <= (div_cnt_reg >= div_top - 8'h01) ? 8'h00 : div_cnt_reg + 8'h01;
            if (master_rise) config_clk_out <= 1'b1;
            if (master_fall) config_clk_out <= 1'b0;
          end
          if (fall && fifo_out_valid)
            dout_out <= fifo_out_data;
          if (rise) begin
            len_cnt_reg <= len_cnt_reg + 24'h1;
            case (ph_reg)
              PH_HDR: begin
                pre_reg <= {pre_reg[2:0], din_s_reg[1]};
                if ({pre_reg[2:0], din_s_reg[1]} == `FCS_PREAMBLE)
                  ph_reg <= PH_LEN;
              end
              PH_LEN: begin
                len_reg <= {len_reg[22:0], din_s_reg[1]};
                len_bits_reg <= len_bits_reg + 5'h1;
                if (len_bits_reg == `FCS_LEN_BITS - 1) begin
                  ph_reg <= PH_FRM;
                  fwd_reg <= 1'b0;
                end
              end
              PH_FRM: begin
                bit_cnt_reg <= bit_cnt_reg + 16'h1;
                // field layout: start bit, data, even-parity error bit
                if (bit_cnt_reg == 16'h0) begin
                  parity_reg <= 1'b0;
                end else if (bit_cnt_reg <= FRAME_BITS) begin
                  parity_reg <= parity_reg ^ din_s_reg[1];
                  if (frm_cnt_reg == 16'h0 && bit_cnt_reg == RATE_BIT_POS &&
                      master_reg && din_s_reg[1] && fast_rate_option_in)
                    fast_rate_out <= 1'b1;
                end else begin
                  bit_cnt_reg <= 16'h0;
                  if (parity_reg != din_s_reg[1]) begin
                    ph_reg <= PH_ERR;
                    cfg_error_out <= 1'b1;
                    init_n_oe_out <= 1'b1;
                    init_n_out <= 1'b0;
                    clk_run_reg <= 1'b0;
                  end else if (frm_cnt_reg == FRAMES-1) begin
                    ph_reg <= PH_PASS;
                    fwd_reg <= 1'b1;
                  end else
                    frm_cnt_reg <= frm_cnt_reg + 16'h1;
                end
              end
              default: ;
            endcase
            if (state_reg == ST_LOAD && ph_reg != PH_HDR && ph_reg != PH_LEN &&
                ph_reg != PH_ERR && len_cnt_reg + 24'h1 == len_reg) begin
              state_reg <= ST_START;
              ph_reg <= PH_IDLE;
            end
            if (state_reg == ST_START) begin
              su_cnt_reg <= su_cnt_reg + 3'h1;
              if (su_cnt_reg + 3'h1 == {1'b0, done_step_in}) done_out <= 1'b1;
              if (su_cnt_reg + 3'h1 == {1'b0, gsr_step_in})  gsr_out <= 1'b0;
              if (su_cnt_reg + 3'h1 == {1'b0, io_step_in})   user_io_en_out <= 1'b1;
              if (su_cnt_reg + 3'h1 == {1'b0, io_step_in})   begin
                low_during_cfg_n_out <= 1'b1;
                high_during_cfg_out <= 1'b0;
              end
              extra_reg <= extra_reg + 3'h1;
              if (extra_reg + 3'h1 == `FCS_EXTRA_CLKS)
                clk_run_reg <= 1'b0;
            end
          end
        end
        default: state_reg <= ST_CLEAR;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> fcs_sequencer_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_chk (
  input wire logic       ref_clk_in,
  input wire logic       sys_rst_in,
  input wire logic       program_n_in,
  input wire logic       init_n_in,
  input wire logic       init_n_oe_out,
  input wire logic       init_n_out,
  input wire logic       config_clk_out,
  input wire logic       config_clk_oe_out,
  input wire logic       dout_out,
  input wire logic       done_out,
  input wire logic       low_during_cfg_n_out,
  input wire logic       high_during_cfg_out,
  input wire logic       gsr_out,
  input wire logic       cfg_error_out,
  input wire logic [2:0] mode_out,
  input wire logic       fast_rate_out,
  input wire logic       fast_rate_option_in
);
  // ==========
  // steps
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  // program passes a 2-stage sync, so allow a few cycles
  sequence prog_held; !program_n_in [*5]; endsequence
  sequence slow_high; config_clk_out [*8]; endsequence
  // ==========
  // checks
  reset_state_a: assert property (disable iff (1'b0) sys_rst_in |=>
    init_n_oe_out && !done_out && high_during_cfg_out && !low_during_cfg_n_out && gsr_out)
    else $error("status outputs wrong after reset");
  clear_init_a: assert property (prog_held |-> init_n_oe_out && !done_out)
    else $error("init not pulled low while program low");
  drain_low_a: assert property (init_n_oe_out |-> !init_n_out)
    else $error("init pin driven high");
  err_init_a: assert property ($rose(cfg_error_out) |-> ##[0:3] init_n_oe_out)
    else $error("frame error did not pull init low");
  err_hold_a: assert property ($rose(cfg_error_out) && program_n_in |=> cfg_error_out [*2])
    else $error("error flag dropped early");
  dout_fall_a: assert property (config_clk_oe_out && $changed(dout_out) |-> !config_clk_out)
    else $error("forwarded data changed while clock high");
  slow_clk_a: assert property (
    $rose(config_clk_out) && !fast_rate_option_in |-> slow_high)
    else $error("config clock too fast without option");
  fast_opt_a: assert property (fast_rate_out |-> fast_rate_option_in)
    else $error("fast rate without option");
  clk_mode_a: assert property (config_clk_oe_out |->
    !(mode_out inside {3'h7, 3'h3, 3'h2, 3'h1}))
    else $error("config clock driven in non-master mode");
  done_init_a: assert property ($rose(done_out) |-> init_n_in && !cfg_error_out)
    else $error("done rose during error or init low");
endmodule
bind fcs_sequencer fcs_chk i_chk (.ref_clk_in, .sys_rst_in, .program_n_in, .init_n_in,
  .init_n_oe_out, .init_n_out, .config_clk_out, .config_clk_oe_out, .dout_out, .done_out,
  .low_during_cfg_n_out, .high_during_cfg_out, .gsr_out, .cfg_error_out, .mode_out,
  .fast_rate_out, .fast_rate_option_in);
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int          LIMIT = 60000;
  localparam logic [55:0] PAT   = {4'h2, 24'h00003C, 20'hFFFFF, 8'hA5};
  logic         ref_clk_in          = 1'h0;
  logic         sys_rst_in          = 1'h1;
  logic         program_n_in        = 1'h1;
  logic         init_hold           = 1'h0;
  logic [2:0]   mode                = 3'h0;
  logic         config_clk_in       = 1'h0;
  logic         read_clk_in         = 1'h0;
  logic [1:0]   done_step_in        = 2'h1;
  logic [1:0]   gsr_step_in         = 2'h2;
  logic [1:0]   io_step_in          = 2'h3;
  logic         fast_rate_option_in = 1'h0;
  logic [0:127] strm                = '1;
  logic [55:0]  sh                  = 56'h0;
  logic         seen                = 1'h0;
  logic         ck_q                = 1'h0;
  logic [2:0]   ev_q                = 3'h0;
  int           cyc                 = 0;
  int           t_d, t_g, t_i;
  int           err_total           = 0;
  int           samples_checked     = 0;
  wire          init_n_oe_out, init_n_out, config_clk_out, config_clk_oe_out, dout_out;
  wire          done_out, low_during_cfg_n_out, high_during_cfg_out, gsr_out, din_in;
  wire          user_io_en_out, cfg_error_out, fast_rate_out;
  wire [2:0]    mode_out;
  // pull-up on the init wire, any party may pull it low
  wire          init_n_in = (init_n_oe_out ? init_n_out : 1'h1) & ~init_hold;
  // {check clock enable, expected enable, mode code}
  logic [4:0]   rows [8] = '{5'h18, 5'h17, 5'h1C, 5'h1E, 5'h13, 5'h12, 5'h11, 5'h05};

  fcs_sequencer #(.FRAMES(2), .POR_CYCLES(50), .INIT_MIN_CYC(20), .SLAVE_WAIT_CY(20)) i_dut (
    .ref_clk_in, .sys_rst_in, .program_n_in, .init_n_in, .init_n_oe_out, .init_n_out,
    .mode_sel0_in(mode[0]), .mode_sel1_in(mode[1]), .mode_sel2_in(mode[2]), .din_in,
    .config_clk_in, .config_clk_out, .config_clk_oe_out, .read_clk_in, .dout_out, .done_out,
    .low_during_cfg_n_out, .high_during_cfg_out, .gsr_out, .user_io_en_out, .cfg_error_out,
    .mode_out, .fast_rate_out, .done_step_in, .gsr_step_in, .io_step_in, .fast_rate_option_in);
  fcs_prom i_prom (.clk_in(config_clk_oe_out & config_clk_out), .ce_n_in(low_during_cfg_n_out),
    .rst_n_in(init_n_in), .strm_in(strm), .data_out(din_in));

  // ==========
  // clocks and monitors
  always #4 ref_clk_in = ~ref_clk_in;
  always #32 config_clk_in = ~config_clk_in;
  always #40 read_clk_in = ~read_clk_in;
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    ck_q <= config_clk_out;
    ev_q <= {done_out, gsr_out, user_io_en_out};
    if (config_clk_out && !ck_q) sh <= {sh[54:0], dout_out};
    if (sh === PAT) seen <= 1'h1;
    if (done_out && !ev_q[2]) t_d <= cyc;
    if (!gsr_out && ev_q[1]) t_g <= cyc;
    if (user_io_en_out && !ev_q[0]) t_i <= cyc;
    if (cyc == LIMIT) begin
      err_total++;
      end_sim();
    end
  end

  // ==========
  // helpers
  // lead ones, header, frame 0 all ones keeps the rate bit set, frame 1 with the parity bit set by bad, then overflow byte
  function automatic logic [0:127] mk(input logic bad);
    mk = {8'hF2, 24'h00003C, 10'h1FE, 1'h0, 8'h3C, bad, 8'hA5, {17{4'hF}}};
  endfunction
  task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
    samples_checked++;
    if (seen_v !== exp_v) begin
      err_total++;
      $display("wrong value at %0t ns: saw %0h, expected %0h", $time, seen_v, exp_v);
    end
  endtask
  task automatic prog();
    program_n_in = 1'h0;
    repeat (20) @(negedge ref_clk_in);
    program_n_in = 1'h1;
  endtask
  task automatic run(input logic f, input logic [5:0] st, input logic bad, input logic p);
    int n;
    n = 0;
    fast_rate_option_in = f;
    {done_step_in, gsr_step_in, io_step_in} = st;
    strm = mk(bad);
    mode = 3'h0;
    seen = 1'h0;
    t_d = 0;
    t_g = 0;
    t_i = 0;
    @(negedge ref_clk_in);
    init_hold = 1'h0;
    if (p)
      prog();
    while (done_out !== 1'h1 && cfg_error_out !== 1'h1 && n < 15000) begin
      @(negedge ref_clk_in);
      n++;
    end
    // room for the start-up steps and the extra clocks
    repeat (1000) @(negedge ref_clk_in);
  endtask
  task automatic end_sim();
    if (err_total == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========
  // sequence
  initial begin
    repeat (8) @(negedge ref_clk_in);
    chk({init_n_oe_out, done_out, high_during_cfg_out, low_during_cfg_n_out, gsr_out}, 5'h15);
    sys_rst_in = 1'h0;
    for (int r = 0; r < 8; r++) begin
      mode = rows[r][2:0];
      prog();
      repeat (400) @(negedge ref_clk_in);
      chk(mode_out, (rows[r][2:0] inside {3'h2, 3'h1}) ? 3'h3 : rows[r][2:0]);
      if (rows[r][4])
        chk(config_clk_oe_out, rows[r][3]);
    end
    run(1'h0, 6'h1B, 1'h0, 1'h1);
    chk({done_out, gsr_out, user_io_en_out, cfg_error_out, fast_rate_out, low_during_cfg_n_out}, 6'h29);
    chk(seen, 1'h1);
    chk({t_d < t_g, t_g < t_i}, 2'h3);
    run(1'h0, 6'h1B, 1'h1, 1'h1);
    chk({cfg_error_out, init_n_oe_out, done_out}, 3'h6);
    init_hold = 1'h1;
    prog();
    repeat (400) @(negedge ref_clk_in);
    chk({cfg_error_out, config_clk_oe_out, done_out, init_n_oe_out}, 4'h0);
    run(1'h1, 6'h39, 1'h0, 1'h0);
    chk({done_out, fast_rate_out, cfg_error_out}, 3'h6);
    chk({t_i < t_g, t_g < t_d}, 2'h3);
    end_sim();
  end
endmodule
`default_nettype wire
